// ### splc_host_model.sv
// Host controller model driving settings, position and origin commands
`timescale 1ns/1ps
module splc_host_model
  import splc_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Position, settings and origin commands
  output logic signed [31:0] position,
  output splc_cfg_t          cfg,
  output logic               origin_return_command,
  output logic               coordinate_set_command,
  output logic               origin_valid_flag
);
  initial begin
    position = '0;
    cfg = '{SPLC_SEL_DEFAULT, SPLC_FWD_DEFAULT, SPLC_REV_DEFAULT};
    origin_return_command = 1'b0;
    coordinate_set_command = 1'b0;
    origin_valid_flag = 1'b0;
  end
  // New settings, no restart; reverse kept below forward
  task automatic setup(input logic [3:0] sel, input logic signed [31:0] fwd, rev);
    @(negedge clk);
    cfg = '{sel, fwd, (rev < fwd) ? rev : fwd - 32'sh1};
  endtask
  task automatic move(input logic signed [31:0] pos);
    @(negedge clk);
    position = pos;
  endtask
  // One-cycle origin pulse; released flag shows its inverse
  task automatic define(input logic ret, input logic flag);
    @(negedge clk);
    origin_return_command = ret;
    coordinate_set_command = !ret;
    origin_valid_flag = flag;
    @(negedge clk);
    origin_return_command = 1'b0;
    coordinate_set_command = 1'b0;
    origin_valid_flag = !flag;
  endtask
endmodule

// ### splc_pkg.sv
// Package for the software position limit checker
package splc_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int POS_W = 32;
  localparam int SEL_W = 4;

  // ----------------------------------------
  // Position limit range and defaults
  // ----------------------------------------
  localparam logic signed [31:0] SPLC_LIM_MAX     = 32'sh3FFFFFFF;
  localparam logic signed [31:0] SPLC_LIM_MIN     = -32'sh3FFFFFFF;
  localparam logic signed [31:0] SPLC_FWD_DEFAULT = SPLC_LIM_MAX;
  localparam logic signed [31:0] SPLC_REV_DEFAULT = SPLC_LIM_MIN;

  // ----------------------------------------
  // Limit select codes (lowest digit)
  // ----------------------------------------
  localparam logic [3:0] SPLC_SEL_BOTH    = 4'h0;
  localparam logic [3:0] SPLC_SEL_NO_FWD  = 4'h1;
  localparam logic [3:0] SPLC_SEL_NO_REV  = 4'h2;
  localparam logic [3:0] SPLC_SEL_DEFAULT = 4'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic SPLC_RST_FLAG = 1'b0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]         limit_select_setting;
    logic signed [31:0] forward_position_limit;
    logic signed [31:0] reverse_position_limit;
  } splc_cfg_t;

  typedef struct packed {
    logic forward_violation;
    logic reverse_violation;
    logic origin_defined;
    logic emergency_stop;
  } splc_stat_t;

endpackage

// ### splc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module splc_sync
  import splc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous input and filtered level
  input  wire logic d,
  output logic      q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  // ----------------------------------------
  // Accept a change once stages two and three agree
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= SPLC_RST_FLAG;
      s2_r <= SPLC_RST_FLAG;
      s3_r <= SPLC_RST_FLAG;
      q_r  <= SPLC_RST_FLAG;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ### splc_top.sv
// Software position limit checker top level
`timescale 1ns/1ps
module splc_top
  import splc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Position and settings
  input  wire logic signed [31:0] position,
  input  wire splc_cfg_t          cfg,
  // Origin definition
  input  wire logic               origin_return_command,
  input  wire logic               coordinate_set_command,
  input  wire logic               origin_valid_flag,
  // Overtravel pins
  input  wire logic               forward_overtravel_input,
  input  wire logic               reverse_overtravel_input,
  // Status
  output splc_stat_t              status
);

  logic               ot_fwd;
  logic               ot_rev;
  logic               fwd_en;
  logic               rev_en;
  logic signed [31:0] fwd_lim_c;
  logic signed [31:0] rev_lim_c;
  logic               origin_r;
  logic               origin_nxt;
  logic               fwd_viol_r;
  logic               fwd_viol_nxt;
  logic               rev_viol_r;
  logic               rev_viol_nxt;
  logic               estop_r;
  logic               estop_nxt;

  // ----------------------------------------
  // Overtravel pin synchronisers
  // ----------------------------------------
  splc_sync u_sync_fwd (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (forward_overtravel_input),
    .q       (ot_fwd)
  );

  splc_sync u_sync_rev (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (reverse_overtravel_input),
    .q       (ot_rev)
  );

  // ----------------------------------------
  // Settings decode and range clamp
  // ----------------------------------------
  always_comb begin
    fwd_en = (cfg.limit_select_setting != SPLC_SEL_NO_FWD);
    rev_en = (cfg.limit_select_setting != SPLC_SEL_NO_REV);
    fwd_lim_c = cfg.forward_position_limit;
    if (cfg.forward_position_limit > SPLC_LIM_MAX) begin
      fwd_lim_c = SPLC_LIM_MAX;
    end else if (cfg.forward_position_limit < SPLC_LIM_MIN) begin
      fwd_lim_c = SPLC_LIM_MIN;
    end
    rev_lim_c = cfg.reverse_position_limit;
    if (cfg.reverse_position_limit > SPLC_LIM_MAX) begin
      rev_lim_c = SPLC_LIM_MAX;
    end else if (cfg.reverse_position_limit < SPLC_LIM_MIN) begin
      rev_lim_c = SPLC_LIM_MIN;
    end
  end

  // ----------------------------------------
  // Origin state
  // ----------------------------------------
  always_comb begin
    origin_nxt = origin_r;
    if (coordinate_set_command && !origin_valid_flag) begin
      origin_nxt = 1'b0;
    end
    if (origin_return_command || (coordinate_set_command && origin_valid_flag)) begin
      origin_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      origin_r <= SPLC_RST_FLAG;
    end else begin
      origin_r <= origin_nxt;
    end
  end

  // ----------------------------------------
  // Limit compare and stop request
  // ----------------------------------------
  always_comb begin
    fwd_viol_nxt = origin_r && fwd_en && (position > fwd_lim_c);
    rev_viol_nxt = origin_r && rev_en && (position < rev_lim_c);
    estop_nxt    = fwd_viol_nxt || rev_viol_nxt || ot_fwd || ot_rev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_viol_r <= SPLC_RST_FLAG;
      rev_viol_r <= SPLC_RST_FLAG;
      estop_r    <= SPLC_RST_FLAG;
    end else begin
      fwd_viol_r <= fwd_viol_nxt;
      rev_viol_r <= rev_viol_nxt;
      estop_r    <= estop_nxt;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign status.forward_violation = fwd_viol_r;
  assign status.reverse_violation = rev_viol_r;
  assign status.origin_defined    = origin_r;
  assign status.emergency_stop    = estop_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_FWD_CMP: assert property (@(posedge clk) disable iff (sys_rst)
    (origin_r && fwd_en && position > fwd_lim_c) |=> fwd_viol_r)
    else $error("forward violation missed");

  AST_REV_CMP: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (rev_viol_r == $past(origin_r && rev_en && position < rev_lim_c)))
    else $error("reverse violation does not match compare");

  AST_NO_ORIGIN: assert property (@(posedge clk) disable iff (sys_rst)
    !origin_r |=> (!fwd_viol_r && !rev_viol_r))
    else $error("violation flagged before origin defined");

  AST_ORIGIN_SET: assert property (@(posedge clk) disable iff (sys_rst)
    (origin_return_command || (coordinate_set_command && origin_valid_flag))
    |=> origin_r)
    else $error("origin not defined after command");

  AST_SEL_NO_FWD: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg.limit_select_setting == SPLC_SEL_NO_FWD) |=> !fwd_viol_r)
    else $error("forward violation with forward limit disabled");

  AST_SEL_IMMEDIATE: assert property (@(posedge clk) disable iff (sys_rst)
    (origin_r && cfg.limit_select_setting == SPLC_SEL_BOTH && position < rev_lim_c)
    |=> rev_viol_r)
    else $error("reverse limit not applied at once");

  AST_ESTOP: assert property (@(posedge clk) disable iff (sys_rst)
    (fwd_viol_r || rev_viol_r) |-> estop_r)
    else $error("violation without emergency stop");

  AST_SOFT_INDEP: assert property (@(posedge clk) disable iff (sys_rst)
    (!ot_fwd && !ot_rev && origin_r && fwd_en && position > fwd_lim_c) |=> estop_r)
    else $error("soft limit stop depends on overtravel");

  AST_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
    (fwd_lim_c <= SPLC_LIM_MAX) && (rev_lim_c >= SPLC_LIM_MIN))
    else $error("limit outside accepted range");

  AST_SEL_NO_REV: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg.limit_select_setting == SPLC_SEL_NO_REV) |=> !rev_viol_r)
    else $error("reverse violation with reverse limit disabled");

  AST_FWD_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
    (position <= fwd_lim_c) |=> !fwd_viol_r)
    else $error("forward violation inside forward limit");

  AST_REV_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
    (position >= rev_lim_c) |=> !rev_viol_r)
    else $error("reverse violation inside reverse limit");

  AST_OT_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    (ot_fwd || ot_rev) |=> estop_r)
    else $error("overtravel without emergency stop");

  AST_STOP_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
    estop_r |-> (fwd_viol_r || rev_viol_r || $past(ot_fwd || ot_rev)))
    else $error("emergency stop without a cause");

  AST_ORIGIN_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    (coordinate_set_command && !origin_valid_flag && !origin_return_command)
    |=> !origin_r)
    else $error("origin kept after coordinate set without valid flag");

  AST_ORIGIN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (!origin_return_command && !coordinate_set_command)
    |=> (origin_r == $past(origin_r)))
    else $error("origin changed without a command");

  AST_FWD_PASS: assert property (@(posedge clk) disable iff (sys_rst)
    ((cfg.forward_position_limit <= SPLC_LIM_MAX) &&
     (cfg.forward_position_limit >= SPLC_LIM_MIN))
    |-> (fwd_lim_c == cfg.forward_position_limit))
    else $error("in-range forward limit altered");

  AST_REV_PASS: assert property (@(posedge clk) disable iff (sys_rst)
    ((cfg.reverse_position_limit <= SPLC_LIM_MAX) &&
     (cfg.reverse_position_limit >= SPLC_LIM_MIN))
    |-> (rev_lim_c == cfg.reverse_position_limit))
    else $error("in-range reverse limit altered");

  COV_CLAMP: cover property (@(posedge clk) disable iff (sys_rst)
    (cfg.forward_position_limit > SPLC_LIM_MAX) && fwd_viol_r);
  COV_CLEAR: cover property (@(posedge clk) disable iff (sys_rst)
    origin_r ##1 !origin_r);
  COV_FWD: cover property (@(posedge clk) disable iff (sys_rst)
    !origin_r ##1 origin_r ##[1:20] fwd_viol_r);
  COV_REV: cover property (@(posedge clk) disable iff (sys_rst) rev_viol_r);
  COV_OT: cover property (@(posedge clk) disable iff (sys_rst)
    estop_r && !fwd_viol_r && !rev_viol_r);

endmodule

// ### splc_top_tb_top.sv
// Testbench for the software position limit checker
`timescale 1ns/1ps
module splc_top_tb_top
  import splc_pkg::*;
;
  logic               clk;
  logic               sys_rst;
  logic signed [31:0] position;
  splc_cfg_t          cfg;
  logic               ret_cmd;
  logic               set_cmd;
  logic               valid_flag;
  logic               fwd_ot;
  logic               rev_ot;
  splc_stat_t         status;
  int                 errors;
  int                 n_checks;

  splc_host_model host (.clk(clk), .position(position), .cfg(cfg),
    .origin_return_command(ret_cmd), .coordinate_set_command(set_cmd),
    .origin_valid_flag(valid_flag));
  splc_top dut (.clk(clk), .sys_rst(sys_rst), .position(position), .cfg(cfg),
    .origin_return_command(ret_cmd), .coordinate_set_command(set_cmd),
    .origin_valid_flag(valid_flag), .forward_overtravel_input(fwd_ot),
    .reverse_overtravel_input(rev_ot), .status(status));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_before_origin();
    host.move(SPLC_LIM_MAX + 32'sh1);
    settle();
    check(status, 4'h0);
    host.move(SPLC_LIM_MIN - 32'sh1);
    settle();
    check(status, 4'h0);
  endtask

  task automatic t_origin_return();
    host.define(1'b1, 1'b0);
    host.move(SPLC_LIM_MAX);
    settle();
    check(status, 4'h2);
    host.move(SPLC_LIM_MAX + 32'sh1);
    settle();
    check(status, 4'hB);
    host.move(SPLC_LIM_MIN - 32'sh1);
    settle();
    check(status, 4'h7);
  endtask

  task automatic t_select();
    for (int s = 0; s < 5; s++) begin
      host.setup(4'(s), 32'sh100, -32'sh100);
      host.move(32'sh101);
      settle();
      check(status, {s != 1, 1'b0, 1'b1, s != 1});
      host.move(-32'sh101);
      settle();
      check(status, {1'b0, s != 2, 1'b1, s != 2});
    end
  endtask

  task automatic t_coord_set();
    host.define(1'b0, 1'b0);
    settle();
    check(status, 4'h0);
    host.define(1'b0, 1'b1);
    settle();
    check(status, 4'h7);
  endtask

  task automatic t_overtravel();
    host.define(1'b0, 1'b0);
    host.move('0);
    for (int i = 1; i < 3; i++) begin
      {rev_ot, fwd_ot} = 2'(i);
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(status, 4'h1);
      {rev_ot, fwd_ot} = 2'b00;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(status, 4'h0);
    end
  endtask

  task automatic t_clamp();
    host.define(1'b1, 1'b0);
    host.setup(4'h3, 32'sh7FFFFFFF, -32'sh7FFFFFFF);
    host.move(SPLC_LIM_MAX + 32'sh1);
    settle();
    check(status, 4'hB);
    host.move(SPLC_LIM_MIN - 32'sh1);
    settle();
    check(status, 4'h7);
  endtask

  initial begin
    sys_rst = 1'b1;
    fwd_ot = 1'b0;
    rev_ot = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_before_origin();
    t_origin_return();
    t_select();
    t_coord_set();
    t_overtravel();
    t_clamp();
    report_and_stop();
  end

  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule
